// ==== core/csms_top.v ====
// Purpose: clock source control, fast oscillator monitor and clock output
//          selector
// Assumes: all oscillator clocks arrive as pins sampled on ref_clk_i
// Notes: clock output is a sampled copy, good for clocks below 10 MHz
//
// Summary of operation
// - fast oscillator bypass chosen by software bit
// - bypass uses input pin, output pin undriven
// - slow oscillator bypass bit in backup register
// - 3-bit selector routes seven clock choices out, or none
// - monitor enable bit in clock control register
// - failure disables fast oscillator, sets fault flag
// - fault drives non-maskable interrupt, not maskable line
// - system clock falls back to 8 MHz RC when fed by failed oscillator
// - PLL disabled when fed by failed oscillator
`timescale 1ns/1ns
`include "csms_regs.vh"
module csms_top #(
  parameter AW = 8,
  parameter MON_CW = 16,
  parameter FAST_EDGES = `CSMS_FAST_STARTUP_EDGES,
  parameter SLOW_EDGES = `CSMS_SLOW_STARTUP_EDGES
) (
  input wire ref_clk_i,
  input wire rst_i,
  input wire [AW-1:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  input wire fast_osc_input_pin_i,
  output reg fast_osc_output_pin_o,
  output reg fast_osc_output_pin_oe_o,
  input wire slow_osc_input_pin_i,
  output reg slow_osc_output_pin_o,
  output reg slow_osc_output_pin_oe_o,
  input wire internal_rc_14mhz_clock_i,
  input wire internal_rc_40khz_clock_i,
  input wire internal_rc_8mhz_clock_i,
  input wire pll_output_clock_i,
  output reg clock_out_o,
  output reg fast_osc_en_o,
  output reg fast_osc_bypass_o,
  output reg slow_osc_en_o,
  output reg slow_osc_bypass_o,
  output reg pll_en_o,
  output reg pll_src_fast_o,
  output reg [1:0] system_clock_sel_o,
  output reg [1:0] rtc_clock_sel_o,
  output reg irq_o,
  output reg nmi_o
);
  localparam integer MON_WIN_N = `CSMS_MON_WINDOW_CYC;
  localparam [MON_CW-1:0] MON_WIN = MON_WIN_N[MON_CW-1:0];
  localparam NSRC = 6;

  reg [`CSMS_CTRL_W-1:0] ctrl_q;
  reg [`CSMS_CFG_W-1:0] cfg_q;
  reg [`CSMS_INT_W-1:0] stat_q;
  reg [`CSMS_INT_W-1:0] mask_q;
  reg [`CSMS_BD_W-1:0] bd_q;
  reg [NSRC-1:0] prev_q;
  reg [4:0] fast_cnt_q;
  reg [4:0] slow_cnt_q;
  reg fast_rdy_q;
  reg slow_rdy_q;
  reg pll_half_q;
  reg [`CSMS_CTRL_W-1:0] ctrl_d;
  reg [`CSMS_CFG_W-1:0] cfg_d;
  reg [`CSMS_INT_W-1:0] stat_d;
  reg [`CSMS_INT_W-1:0] set_d;
  reg [31:0] rdata_d;
  reg sys_lvl;
  reg out_d;
  wire [NSRC-1:0] pins;
  wire [NSRC-1:0] lvl;
  wire [NSRC-1:0] rise;
  wire fault;
  wire fast_rise_ok;
  wire slow_rise_ok;
  wire wr_ctrl;
  wire wr_cfg;
  wire wr_stat;
  wire wr_mask;
  wire wr_bd;
  wire fast_fed;
  wire fast_rdy_d;
  wire slow_rdy_d;

  // bit order of the sampled clocks
  localparam I_FAST = 0;
  localparam I_SLOW = 1;
  localparam I_R14 = 2;
  localparam I_R40 = 3;
  localparam I_R8 = 4;
  localparam I_PLL = 5;

  function hit;
    input [AW-1:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs[AW-1:0]);
    end
  endfunction

  // system clock field, read by the selectors and by the fault takeover
  function [1:0] sys_of;
    input [`CSMS_CFG_W-1:0] c;
    begin
      sys_of = c[`CSMS_CFG_SYS_HI:`CSMS_CFG_SYS_LO];
    end
  endfunction

  // an oscillator is ready once its edge count reached the target
  function done_at;
    input en;
    input [4:0] cnt;
    input [4:0] target;
    begin
      done_at = en & (cnt == target);
    end
  endfunction

  assign pins = {pll_output_clock_i, internal_rc_8mhz_clock_i,
                 internal_rc_40khz_clock_i, internal_rc_14mhz_clock_i,
                 slow_osc_input_pin_i, fast_osc_input_pin_i};

  csms_sync #(
    .W(NSRC)
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .async_i(pins),
    .sync_o(lvl)
  );

  assign rise = lvl & ~prev_q;

  // a stopped oscillator shows no edges; bypass and crystal look the same
  assign fast_rise_ok = rise[I_FAST] & ctrl_q[`CSMS_CTRL_FAST_EN];
  assign slow_rise_ok = rise[I_SLOW] & bd_q[`CSMS_BD_SLOW_EN];

  // monitor only counts once the oscillator has started; the ready gate also
  // stops it one cycle after the fast enable is cleared
  csms_mon #(
    .CW(MON_CW),
    .WINDOW(MON_WIN)
  ) u_mon (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .en_i(ctrl_q[`CSMS_CTRL_MON_EN] & fast_rdy_q),
    .edge_i(fast_rise_ok),
    .fault_o(fault)
  );

  // one decoded strobe per register keeps the write paths alike
  assign wr_ctrl = wr_i & hit(addr_i, `CSMS_OFS_CTRL);
  assign wr_cfg = wr_i & hit(addr_i, `CSMS_OFS_CFG);
  assign wr_stat = wr_i & hit(addr_i, `CSMS_OFS_INT_STAT);
  assign wr_mask = wr_i & hit(addr_i, `CSMS_OFS_INT_MASK);
  assign wr_bd = wr_i & hit(addr_i, `CSMS_OFS_BDCTL);
  assign fast_rdy_d = done_at(ctrl_q[`CSMS_CTRL_FAST_EN], fast_cnt_q,
                              FAST_EDGES[4:0]);
  assign slow_rdy_d = done_at(bd_q[`CSMS_BD_SLOW_EN], slow_cnt_q,
                              SLOW_EDGES[4:0]);

  // the system clock depends on the fast oscillator, directly or via the
  // pll; only then does a fault move it to the internal RC
  assign fast_fed = (sys_of(cfg_q) == `CSMS_SYS_FAST) ||
                    (sys_of(cfg_q) == `CSMS_SYS_PLL &&
                     ctrl_q[`CSMS_CTRL_PLL_SRC]);

  // control and config, with hardware takeover on a fault
  always @* begin
    ctrl_d = ctrl_q;
    cfg_d = cfg_q;
    if (wr_ctrl) begin
      ctrl_d = wdata_i[`CSMS_CTRL_W-1:0];
    end
    if (wr_cfg) begin
      cfg_d = wdata_i[`CSMS_CFG_W-1:0];
    end
    // hardware wins over a write landing in the fault cycle
    if (fault) begin
      ctrl_d[`CSMS_CTRL_FAST_EN] = 1'b0;
      if (ctrl_q[`CSMS_CTRL_PLL_SRC]) begin
        ctrl_d[`CSMS_CTRL_PLL_EN] = 1'b0;
      end
      if (fast_fed) begin
        cfg_d[`CSMS_CFG_SYS_HI:`CSMS_CFG_SYS_LO] = `CSMS_SYS_INTERNAL_RC_8MHZ_OSC;
      end
      // real-time clock select is left alone on purpose
    end
  end

  // sticky status: a new event beats a write-one clear in the same cycle
  always @* begin
    set_d = {`CSMS_INT_W{1'b0}};
    set_d[`CSMS_INT_FAULT] = fault;
    set_d[`CSMS_INT_FAST_RDY] = fast_rdy_d & ~fast_rdy_q;
    set_d[`CSMS_INT_SLOW_RDY] = slow_rdy_d & ~slow_rdy_q;
    stat_d = stat_q;
    if (wr_stat) begin
      stat_d = stat_d & ~wdata_i[`CSMS_INT_W-1:0];
    end
    stat_d = stat_d | set_d;
  end

  // current system clock level, from the registered config now in use
  always @* begin
    case (sys_of(cfg_q))
      `CSMS_SYS_FAST: sys_lvl = lvl[I_FAST];
      `CSMS_SYS_PLL: sys_lvl = lvl[I_PLL];
      default: sys_lvl = lvl[I_R8];
    endcase
  end

  // clock output selector
  always @* begin
    case (cfg_q[`CSMS_CFG_OUT_HI:`CSMS_CFG_OUT_LO])
      `CSMS_OUT_NONE: out_d = 1'b0;
      `CSMS_OUT_IRC14M: out_d = lvl[I_R14];
      `CSMS_OUT_IRC40K: out_d = lvl[I_R40];
      `CSMS_OUT_SLOW: out_d = lvl[I_SLOW] & bd_q[`CSMS_BD_SLOW_EN];
      `CSMS_OUT_SYS: out_d = sys_lvl;
      `CSMS_OUT_INTERNAL_RC_8MHZ_OSC: out_d = lvl[I_R8];
      `CSMS_OUT_FAST: out_d = lvl[I_FAST] & ctrl_q[`CSMS_CTRL_FAST_EN];
      `CSMS_OUT_PLL: out_d = cfg_q[`CSMS_CFG_PLL_DIV2] ? pll_half_q :
                             lvl[I_PLL];
      default: out_d = 1'b0;
    endcase
  end

  // read mux; unmapped addresses read zero
  always @* begin
    rdata_d = 32'h0000_0000;
    if (hit(addr_i, `CSMS_OFS_CTRL)) begin
      rdata_d[`CSMS_CTRL_W-1:0] = ctrl_q;
    end else if (hit(addr_i, `CSMS_OFS_CFG)) begin
      rdata_d[`CSMS_CFG_W-1:0] = cfg_q;
    end else if (hit(addr_i, `CSMS_OFS_INT_STAT)) begin
      rdata_d[`CSMS_INT_W-1:0] = stat_q;
    end else if (hit(addr_i, `CSMS_OFS_INT_MASK)) begin
      rdata_d[`CSMS_INT_W-1:0] = mask_q;
    end else if (hit(addr_i, `CSMS_OFS_BDCTL)) begin
      rdata_d[`CSMS_BD_W-1:0] = bd_q;
    end else if (hit(addr_i, `CSMS_OFS_STATE)) begin
      rdata_d[0] = fast_rdy_q;
      rdata_d[1] = slow_rdy_q;
      rdata_d[3:2] = system_clock_sel_o;
      rdata_d[4] = pll_en_o;
    end
  end

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q <= `CSMS_CTRL_RST;
      cfg_q <= `CSMS_CFG_RST;
      stat_q <= `CSMS_INT_RST;
      mask_q <= `CSMS_INT_RST;
      bd_q <= `CSMS_BD_RST;
      prev_q <= {NSRC{1'b0}};
      fast_cnt_q <= 5'h00;
      slow_cnt_q <= 5'h00;
      fast_rdy_q <= 1'b0;
      slow_rdy_q <= 1'b0;
      pll_half_q <= 1'b0;
      rdata_o <= 32'h0000_0000;
    end else begin
      ctrl_q <= ctrl_d;
      cfg_q <= cfg_d;
      stat_q <= stat_d;
      prev_q <= lvl;
      if (wr_mask) begin
        mask_q <= wdata_i[`CSMS_INT_W-1:0];
      end
      if (wr_bd) begin
        bd_q <= wdata_i[`CSMS_BD_W-1:0];
      end
      if (rd_i) begin
        rdata_o <= rdata_d;
      end else begin
        rdata_o <= 32'h0000_0000;
      end
      // startup edge counters, held at the target once reached
      if (!ctrl_q[`CSMS_CTRL_FAST_EN]) begin
        fast_cnt_q <= 5'h00;
      end else if (fast_rise_ok && !fast_rdy_d) begin
        fast_cnt_q <= fast_cnt_q + 5'h01;
      end
      if (!bd_q[`CSMS_BD_SLOW_EN]) begin
        slow_cnt_q <= 5'h00;
      end else if (slow_rise_ok && !slow_rdy_d) begin
        slow_cnt_q <= slow_cnt_q + 5'h01;
      end
      fast_rdy_q <= fast_rdy_d;
      slow_rdy_q <= slow_rdy_d;
      if (rise[I_PLL]) begin
        pll_half_q <= ~pll_half_q;
      end
    end
  end

  // registered outputs
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fast_osc_output_pin_o <= 1'b0;
      fast_osc_output_pin_oe_o <= 1'b0;
      slow_osc_output_pin_o <= 1'b0;
      slow_osc_output_pin_oe_o <= 1'b0;
      clock_out_o <= 1'b0;
      fast_osc_en_o <= 1'b0;
      fast_osc_bypass_o <= 1'b0;
      slow_osc_en_o <= 1'b0;
      slow_osc_bypass_o <= 1'b0;
      pll_en_o <= 1'b0;
      pll_src_fast_o <= 1'b0;
      system_clock_sel_o <= `CSMS_SYS_INTERNAL_RC_8MHZ_OSC;
      rtc_clock_sel_o <= 2'h0;
      irq_o <= 1'b0;
      nmi_o <= 1'b0;
    end else begin
      // crystal drive is the inverted input; bypass leaves the pin floating
      fast_osc_output_pin_o <= ~lvl[I_FAST];
      fast_osc_output_pin_oe_o <= ctrl_d[`CSMS_CTRL_FAST_EN] &
                                  ~ctrl_d[`CSMS_CTRL_FAST_BYP];
      slow_osc_output_pin_o <= ~lvl[I_SLOW];
      slow_osc_output_pin_oe_o <= bd_q[`CSMS_BD_SLOW_EN] &
                                  ~bd_q[`CSMS_BD_SLOW_BYP];
      clock_out_o <= out_d;
      fast_osc_en_o <= ctrl_d[`CSMS_CTRL_FAST_EN];
      fast_osc_bypass_o <= ctrl_d[`CSMS_CTRL_FAST_BYP];
      slow_osc_en_o <= bd_q[`CSMS_BD_SLOW_EN];
      slow_osc_bypass_o <= bd_q[`CSMS_BD_SLOW_BYP];
      pll_en_o <= ctrl_d[`CSMS_CTRL_PLL_EN];
      pll_src_fast_o <= ctrl_d[`CSMS_CTRL_PLL_SRC];
      system_clock_sel_o <= sys_of(cfg_d);
      rtc_clock_sel_o <= bd_q[`CSMS_BD_RTC_HI:`CSMS_BD_RTC_LO];
      // the fault bit never reaches the maskable line
      irq_o <= |(stat_d & mask_q &
                 ~(`CSMS_INT_W'h1 << `CSMS_INT_FAULT));
      nmi_o <= stat_d[`CSMS_INT_FAULT];
    end
  end
endmodule

// ==== core/csms_regs.vh ====
// Purpose: register offsets, fields, reset values and timing counts for the
//          clock source, monitor and select block
// Assumes: one 20 MHz reference clock, byte addresses on a plain port
// Notes: definitions only
`ifndef CSMS_REGS_VH
`define CSMS_REGS_VH

// register byte offsets
`define CSMS_OFS_CTRL 8'h00
`define CSMS_OFS_CFG 8'h04
`define CSMS_OFS_INT_STAT 8'h08
`define CSMS_OFS_INT_MASK 8'h0c
`define CSMS_OFS_BDCTL 8'h10
`define CSMS_OFS_STATE 8'h14

// clock control register fields
`define CSMS_CTRL_FAST_EN 0
`define CSMS_CTRL_FAST_BYP 1
`define CSMS_CTRL_MON_EN 2
`define CSMS_CTRL_PLL_EN 3
`define CSMS_CTRL_PLL_SRC 4
`define CSMS_CTRL_W 5
`define CSMS_CTRL_RST 5'h00

// clock config register fields
`define CSMS_CFG_SYS_LO 0
`define CSMS_CFG_SYS_HI 1
`define CSMS_CFG_OUT_LO 2
`define CSMS_CFG_OUT_HI 4
`define CSMS_CFG_PLL_DIV2 5
`define CSMS_CFG_W 6
`define CSMS_CFG_RST 6'h00

// system clock source codes
`define CSMS_SYS_INTERNAL_RC_8MHZ_OSC 2'h0
`define CSMS_SYS_FAST 2'h1
`define CSMS_SYS_PLL 2'h2

// clock output selector codes
`define CSMS_OUT_NONE 3'h0
`define CSMS_OUT_IRC14M 3'h1
`define CSMS_OUT_IRC40K 3'h2
`define CSMS_OUT_SLOW 3'h3
`define CSMS_OUT_SYS 3'h4
`define CSMS_OUT_INTERNAL_RC_8MHZ_OSC 3'h5
`define CSMS_OUT_FAST 3'h6
`define CSMS_OUT_PLL 3'h7

// interrupt status and mask fields
`define CSMS_INT_FAULT 0
`define CSMS_INT_FAST_RDY 1
`define CSMS_INT_SLOW_RDY 2
`define CSMS_INT_W 3
`define CSMS_INT_RST 3'h0

// backup domain control register fields
`define CSMS_BD_SLOW_EN 0
`define CSMS_BD_SLOW_BYP 1
`define CSMS_BD_RTC_LO 2
`define CSMS_BD_RTC_HI 3
`define CSMS_BD_W 4
`define CSMS_BD_RST 4'h0

// timing
`define CSMS_CLK_PERIOD_NS 50
`define CSMS_MON_WINDOW_NS 10000
`define CSMS_MON_WINDOW_CYC (`CSMS_MON_WINDOW_NS / `CSMS_CLK_PERIOD_NS)
`define CSMS_FAST_STARTUP_EDGES 16
`define CSMS_SLOW_STARTUP_EDGES 4

`endif

// ==== core/csms_sync.v ====
// Purpose: two flip-flop synchroniser for a group of pin levels
// Assumes: inputs are asynchronous to ref_clk_i
// Notes: only the second stage leaves this module
`timescale 1ns/1ns
module csms_sync #(
  parameter W = 1
) (
  input wire ref_clk_i,
  input wire rst_i,
  input wire [W-1:0] async_i,
  output reg [W-1:0] sync_o
);
  reg [W-1:0] meta_q;

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= {W{1'b0}};
      sync_o <= {W{1'b0}};
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule

// ==== core/csms_mon.v ====
// Purpose: fast oscillator failure watchdog counted on the reference clock
// Assumes: edge_i is a one-cycle pulse per seen oscillator edge
// Notes: fault_o pulses once per empty window
`timescale 1ns/1ns
module csms_mon #(
  parameter CW = 16,
  parameter [CW-1:0] WINDOW = 16'd200
) (
  input wire ref_clk_i,
  input wire rst_i,
  input wire en_i,
  input wire edge_i,
  output reg fault_o
);
  reg [CW-1:0] cnt_q;

  // counting on the reference clock keeps detection alive when the
  // watched oscillator stops outright
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= {CW{1'b0}};
      fault_o <= 1'b0;
    end else begin
      fault_o <= 1'b0;
      if (!en_i || edge_i) begin
        cnt_q <= {CW{1'b0}};
      end else if (cnt_q == WINDOW - 1'b1) begin
        cnt_q <= {CW{1'b0}};
        fault_o <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end
endmodule

// ==== dv/csms_checker.sv ====
// Purpose: port assertions for the clock source, monitor and select block
// Assumes: one reference clock, reset asynchronous and active high
// Notes: bound onto csms_top at the foot of this file
`timescale 1ns/1ns
module csms_checker (
  input wire ref_clk_i,
  input wire rst_i,
  input wire wr_i,
  input wire rd_i,
  input wire [31:0] rdata_o,
  input wire fast_osc_input_pin_i,
  input wire fast_osc_output_pin_o,
  input wire slow_osc_input_pin_i,
  input wire slow_osc_output_pin_o,
  input wire fast_osc_output_pin_oe_o,
  input wire slow_osc_output_pin_oe_o,
  input wire fast_osc_en_o,
  input wire fast_osc_bypass_o,
  input wire slow_osc_en_o,
  input wire slow_osc_bypass_o,
  input wire pll_en_o,
  input wire pll_src_fast_o,
  input wire [1:0] system_clock_sel_o,
  input wire irq_o,
  input wire nmi_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  localparam int QUIET_MIN = 190;
  logic [15:0] quiet_q;
  logic pin_q;
  // cycles since the last raw rising pin edge, saturating
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      quiet_q <= 16'h0000;
      pin_q <= 1'h0;
    end else begin
      pin_q <= fast_osc_input_pin_i;
      if (fast_osc_input_pin_i && !pin_q)
        quiet_q <= 16'h0000;
      else if (quiet_q != 16'hffff)
        quiet_q <= quiet_q + 16'h0001;
    end
  end
  sequence fault_s;
    $rose(nmi_o);
  endsequence
  fast_drive_a: assert property (fast_osc_output_pin_oe_o ==
    (fast_osc_en_o && !fast_osc_bypass_o)) else $error("fast pin drive");
  slow_drive_a: assert property (slow_osc_output_pin_oe_o ==
    (slow_osc_en_o && !slow_osc_bypass_o)) else $error("slow pin drive");
  rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data outside its cycle");
  fault_stop_a: assert property (fault_s |-> !fast_osc_en_o)
    else $error("oscillator left on after fault");
  nmi_only_a: assert property (fault_s |-> !$rose(irq_o))
    else $error("fault reached maskable line");
  fault_sys_a: assert property (fault_s ##0
    ($past(system_clock_sel_o) == 2'h1) |-> system_clock_sel_o == 2'h0)
    else $error("system clock kept failed source");
  fault_pll_a: assert property (fault_s ##0
    $past(pll_src_fast_o) |-> !pll_en_o) else $error("pll left on");
  fault_quiet_a: assert property (fault_s |-> quiet_q >= QUIET_MIN)
    else $error("fault before empty window");
  nmi_hold_a: assert property ($fell(nmi_o) |->
    $past(wr_i) || $past(wr_i, 2)) else $error("fault flag not sticky");
  fast_xtal_a: assert property (!$past(rst_i, 3) |->
    fast_osc_output_pin_o == !$past(fast_osc_input_pin_i, 3))
    else $error("fast crystal drive not inverted input");
  slow_xtal_a: assert property (!$past(rst_i, 3) |->
    slow_osc_output_pin_o == !$past(slow_osc_input_pin_i, 3))
    else $error("slow crystal drive not inverted input");
endmodule

bind csms_top csms_checker u_chk (
  .ref_clk_i, .rst_i, .wr_i, .rd_i, .rdata_o, .fast_osc_input_pin_i,
  .fast_osc_output_pin_o, .slow_osc_input_pin_i, .slow_osc_output_pin_o,
  .fast_osc_output_pin_oe_o, .slow_osc_output_pin_oe_o, .fast_osc_en_o,
  .fast_osc_bypass_o, .slow_osc_en_o, .slow_osc_bypass_o, .pll_en_o,
  .pll_src_fast_o, .system_clock_sel_o, .irq_o, .nmi_o);

// ==== dv/csms_osc_model.sv ====
// Purpose: behavioural crystal or clock source on one pin
// Assumes: run_i comes from the bench, en_i from the block
// Notes: a dead source holds its last level, as a stuck crystal would
`timescale 1ns/1ns
module csms_osc_model #(
  parameter HALF = 100
) (
  input wire run_i,
  input wire en_i,
  output logic pin_o
);
  initial pin_o = 1'h0;
  always #HALF begin
    if (run_i && en_i)
      pin_o = ~pin_o;
  end
endmodule

// ==== dv/clock_source_monitor_select_tb.sv ====
// Purpose: bench for the clock source, monitor and select block
// Assumes: sources kept below 5 MHz so the sampled clock out keeps up
// Notes: register calls with expected values, no random stimulus
`timescale 1ns/1ns
`include "csms_regs.vh"
module clock_source_monitor_select_tb;
  localparam int HP[6] = '{150, 1000, 110, 2000, 130, 170};
  localparam int SRC[8] = '{0, 2, 3, 1, 4, 4, 0, 5};
  logic ref_clk_i, rst_i, wr_i, rd_i;
  logic [7:0] addr_i;
  logic [31:0] wdata_i;
  logic [5:0] run;
  wire [31:0] rdata_o;
  wire [1:0] system_clock_sel_o, rtc_clock_sel_o;
  wire [5:0] pins, ena;
  wire fast_osc_output_pin_o, fast_osc_output_pin_oe_o, clock_out_o;
  wire slow_osc_output_pin_o, slow_osc_output_pin_oe_o, irq_o, nmi_o;
  wire fast_osc_en_o, fast_osc_bypass_o, slow_osc_en_o, slow_osc_bypass_o;
  wire pll_en_o, pll_src_fast_o;
  int bad_count = 0;
  int cmp_count = 0;
  assign ena = {pll_en_o, 3'h7, slow_osc_en_o, fast_osc_en_o};
  for (genvar k = 0; k < 6; k++) begin : g_osc
    csms_osc_model #(.HALF(HP[k])) u_osc (
      .run_i(run[k]), .en_i(ena[k]), .pin_o(pins[k]));
  end
  csms_top u_dut (
    .ref_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .fast_osc_input_pin_i(pins[0]), .fast_osc_output_pin_o,
    .fast_osc_output_pin_oe_o, .slow_osc_input_pin_i(pins[1]),
    .slow_osc_output_pin_o, .slow_osc_output_pin_oe_o,
    .internal_rc_14mhz_clock_i(pins[2]), .internal_rc_40khz_clock_i(pins[3]),
    .internal_rc_8mhz_clock_i(pins[4]), .pll_output_clock_i(pins[5]),
    .clock_out_o, .fast_osc_en_o, .fast_osc_bypass_o, .slow_osc_en_o,
    .slow_osc_bypass_o, .pll_en_o, .pll_src_fast_o, .system_clock_sel_o,
    .rtc_clock_sel_o, .irq_o, .nmi_o);
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'h1;
    @(posedge ref_clk_i);
    wr_i <= 1'h0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'h1;
    @(posedge ref_clk_i);
    rd_i <= 1'h0;
    #1 d = rdata_o;
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    check("register", v, e);
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic report_and_stop;
    if (bad_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // edges are counted on sampled levels, so both counts may differ by one
  task automatic count_rises(input int c, output int no, output int ns);
    logic po, ps;
    no = 0;
    ns = 0;
    po = clock_out_o;
    ps = pins[SRC[c]];
    repeat (400) begin
      @(posedge ref_clk_i);
      #1;
      no += int'(clock_out_o && !po);
      ns += int'(pins[SRC[c]] && !ps);
      po = clock_out_o;
      ps = pins[SRC[c]];
    end
  endtask
  initial begin
    ref_clk_i = 1'h0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  // tests take about 5600 cycles; over five times that is a hang
  initial begin
    #1600000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    logic [31:0] v;
    int n, m, e, c;
    rst_i = 1'h1;
    wr_i = 1'h0;
    rd_i = 1'h0;
    addr_i = 8'h00;
    wdata_i = 32'h0;
    run = 6'h3f;
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'h0;
    for (int a = 0; a < 32; a += 4)
      chk(a[7:0], 32'h0);
    wr(8'h18, 32'hffffffff);
    chk(8'h18, 32'h0);
    wr(`CSMS_OFS_CTRL, 32'h1);
    check("fast", {fast_osc_en_o, fast_osc_bypass_o,
      fast_osc_output_pin_oe_o}, 32'h5);
    wr(`CSMS_OFS_CTRL, 32'h3);
    check("bypass", {fast_osc_en_o, fast_osc_bypass_o,
      fast_osc_output_pin_oe_o}, 32'h6);
    wr(`CSMS_OFS_BDCTL, 32'hf);
    // backup bits reach the slow outputs one cycle after the write
    cycles(1);
    check("slow", {slow_osc_en_o, slow_osc_bypass_o,
      slow_osc_output_pin_oe_o, rtc_clock_sel_o}, 32'h1b);
    wr(`CSMS_OFS_BDCTL, 32'hd);
    cycles(1);
    check("slow", {slow_osc_en_o, slow_osc_bypass_o,
      slow_osc_output_pin_oe_o, rtc_clock_sel_o}, 32'h17);
    wr(`CSMS_OFS_CTRL, 32'h9);
    cycles(250);
    chk(`CSMS_OFS_STATE, 32'h13);
    chk(`CSMS_OFS_INT_STAT, 32'h6);
    check("irq", irq_o, 32'h0);
    wr(`CSMS_OFS_INT_MASK, 32'h6);
    cycles(2);
    check("irq", irq_o, 32'h1);
    wr(`CSMS_OFS_INT_STAT, 32'h6);
    cycles(2);
    check("irq", irq_o, 32'h0);
    chk(`CSMS_OFS_INT_STAT, 32'h0);
    for (int s = 0; s < 9; s++) begin
      c = s > 7 ? 7 : s;
      wr(`CSMS_OFS_CFG, s > 7 ? 32'h3c : 32'(s) << 2);
      cycles(20);
      count_rises(c, n, m);
      e = c == 0 ? 0 : (s > 7 ? m / 2 : m);
      check("clock_out", 32'((n <= e + 1) && (n + 1 >= e) &&
        (e > 0 || n == 0)), 32'h1);
    end
    // fault bit alone in the mask must never reach the maskable line
    wr(`CSMS_OFS_INT_MASK, 32'h1);
    for (int i = 0; i < 2; i++) begin
      run[0] <= 1'h1;
      wr(`CSMS_OFS_CTRL, i ? 32'h09 : 32'h19);
      wr(`CSMS_OFS_CFG, i ? 32'h2 : 32'h1);
      cycles(150);
      // monitor armed only once the oscillator is up
      wr(`CSMS_OFS_CTRL, i ? 32'h0d : 32'h1d);
      cycles(400);
      check("early_fault", nmi_o, 32'h0);
      run[0] <= 1'h0;
      n = 0;
      while (nmi_o !== 1'h1 && n < 300) begin
        @(posedge ref_clk_i);
        n++;
      end
      #1;
      check("window", 32'(n >= 190 && n <= 215), 32'h1);
      check("fault", {nmi_o, irq_o, fast_osc_en_o}, 32'h4);
      check("fallback", {pll_en_o, system_clock_sel_o},
        i ? 32'h6 : 32'h0);
      check("rtc", rtc_clock_sel_o, i ? 32'h1 : 32'h3);
      // software, not the fault, picks the new real-time clock source
      wr(`CSMS_OFS_BDCTL, 32'h5);
      cycles(1);
      check("rtc_new", rtc_clock_sel_o, 32'h1);
      rd(`CSMS_OFS_INT_STAT, v);
      check("flag", v[0], 32'h1);
      wr(`CSMS_OFS_INT_STAT, 32'h1);
      cycles(2);
      check("nmi_clear", nmi_o, 32'h0);
    end
    report_and_stop();
  end
endmodule
